// file: bso_pkg.sv
package bso_pkg;

	// Data width of the shifter and of every register except the 4-bit control and 2-bit status registers.
	localparam int DATA_W = 32;

	// Register byte offsets on the control bus.
	localparam logic [7:0] ADDR_INSTR = 8'h00;
	localparam logic [7:0] ADDR_SRC = 8'h04;
	localparam logic [7:0] ADDR_AMT = 8'h08;
	localparam logic [7:0] ADDR_CTRL = 8'h0C;
	localparam logic [7:0] ADDR_PC = 8'h10;
	localparam logic [7:0] ADDR_RESULT = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_FIRST = 8'h1C;
	localparam logic [7:0] ADDR_FIRST_OUT = 8'h20;

	// Values after reset.
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [3:0] RESET_CTRL = 4'h0;

	// Control register fields.
	localparam int CTRL_CARRY = 0;
	localparam int CTRL_SRC_PC = 1;
	localparam int CTRL_AMT_PC = 2;
	localparam int CTRL_FIRST_PC = 3;

	// Status register fields.
	localparam int STAT_CARRY = 0;
	localparam int STAT_UNPRED = 1;

	// Instruction word fields.
	localparam int IMM_SEL_BIT = 25;
	localparam int ROT_HI = 11;
	localparam int ROT_LO = 8;
	localparam int IMM8_HI = 7;
	localparam int IMM8_LO = 0;
	localparam int SHAMT_HI = 11;
	localparam int SHAMT_LO = 7;
	localparam int TYPE_HI = 6;
	localparam int TYPE_LO = 5;
	localparam int BY_REG_BIT = 4;

	// Program counter reads ahead of the current instruction by this much.
	localparam logic [31:0] PC_AHEAD = 32'h0000_0008;

	// Full word width as a shift amount.
	localparam logic [7:0] FULL_SHIFT = 8'h20;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Shift types carried in the instruction.
	typedef enum logic [1:0] {
		LEFT_LOGICAL_SHIFT = 2'h0,
		RIGHT_LOGICAL_SHIFT = 2'h1,
		RIGHT_ARITHMETIC_SHIFT = 2'h2,
		RIGHT_ROTATION = 2'h3
	} bso_shift_t;

endpackage : bso_pkg

// file: bso_shift_core.sv
module bso_shift_core
	import bso_pkg::*;
(
	input wire logic [31:0] instr,
	input wire logic [31:0] source_value_reg,
	input wire logic [31:0] shift_amount_reg,
	input wire logic carry_flag,
	output logic [31:0] operand,
	output logic carry
);

	logic [4:0] rot2;
	logic [63:0] imm_pair;
	logic [31:0] imm_val;
	logic [4:0] sh5;
	logic [7:0] n;
	logic [4:0] n5;
	logic [63:0] src_pair;
	logic [31:0] sign_fill;
	bso_shift_t kind;

	// Immediate form: 8-bit constant rotated right by twice the rotate field.
	assign rot2 = {instr[ROT_HI:ROT_LO], 1'b0};
	assign imm_pair = {24'h000000, instr[IMM8_HI:IMM8_LO], 24'h000000, instr[IMM8_HI:IMM8_LO]};
	assign imm_val = 32'(imm_pair >> rot2);
	assign sh5 = instr[SHAMT_HI:SHAMT_LO];
	assign n = shift_amount_reg[7:0];
	assign n5 = n[4:0];
	assign src_pair = {source_value_reg, source_value_reg};
	assign sign_fill = {32{source_value_reg[31]}};
	assign kind = bso_shift_t'(instr[TYPE_HI:TYPE_LO]);

	// Operand and carry selection; purely combinational, no state kept.
	always_comb begin
		operand = source_value_reg;
		carry = carry_flag;
		if (instr[IMM_SEL_BIT]) begin
			operand = imm_val;
			carry = (instr[ROT_HI:ROT_LO] == 4'h0) ? carry_flag : imm_val[31];
		end else if (!instr[BY_REG_BIT]) begin
			case (kind)
				LEFT_LOGICAL_SHIFT: begin
					if (sh5 != 5'h00) begin
						operand = source_value_reg << sh5;
						carry = source_value_reg[5'(6'h20 - {1'b0, sh5})];
					end
				end
				RIGHT_LOGICAL_SHIFT: begin
					if (sh5 == 5'h00) begin
						operand = 32'h0000_0000;
						carry = source_value_reg[31];
					end else begin
						operand = source_value_reg >> sh5;
						carry = source_value_reg[sh5 - 5'h01];
					end
				end
				RIGHT_ARITHMETIC_SHIFT: begin
					if (sh5 == 5'h00) begin
						operand = sign_fill;
						carry = source_value_reg[31];
					end else begin
						operand = 32'($signed(source_value_reg) >>> sh5);
						carry = source_value_reg[sh5 - 5'h01];
					end
				end
				default: begin
					if (sh5 == 5'h00) begin
						operand = {carry_flag, source_value_reg[31:1]};
						carry = source_value_reg[0];
					end else begin
						operand = 32'(src_pair >> sh5);
						carry = source_value_reg[sh5 - 5'h01];
					end
				end
			endcase
		end else if (n != 8'h00) begin
			case (kind)
				LEFT_LOGICAL_SHIFT: begin
					if (n < FULL_SHIFT) begin
						operand = source_value_reg << n5;
						carry = source_value_reg[5'(6'h20 - {1'b0, n5})];
					end else begin
						operand = 32'h0000_0000;
						carry = (n == FULL_SHIFT) ? source_value_reg[0] : 1'b0;
					end
				end
				RIGHT_LOGICAL_SHIFT: begin
					if (n < FULL_SHIFT) begin
						operand = source_value_reg >> n5;
						carry = source_value_reg[n5 - 5'h01];
					end else begin
						operand = 32'h0000_0000;
						carry = (n == FULL_SHIFT) ? source_value_reg[31] : 1'b0;
					end
				end
				RIGHT_ARITHMETIC_SHIFT: begin
					if (n < FULL_SHIFT) begin
						operand = 32'($signed(source_value_reg) >>> n5);
						carry = source_value_reg[n5 - 5'h01];
					end else begin
						operand = sign_fill;
						carry = source_value_reg[31];
					end
				end
				default: begin
					if (n5 == 5'h00) begin
						carry = source_value_reg[31];
					end else begin
						operand = 32'(src_pair >> n5);
						carry = source_value_reg[n5 - 5'h01];
					end
				end
			endcase
		end
	end

endmodule : bso_shift_core

// file: bso_operand_gen.sv
// Contract
// - Eleven operand forms: immediate, register, four shift types by immediate or register, extend.
// - Immediate: 8-bit constant rotated right by twice the 4-bit rotate field.
// - Immediate carry: carry flag if rotate field zero, else operand bit 31.
// - Plain register: operand is the source unchanged, carry is the carry flag.
// - Plain register is left logical shift by immediate zero.
// - Program counter as source or base in immediate forms reads address plus 8.
// - Left shift immediate 0..31, zero fill; carry is source bit 32 minus amount.
// - Left shift by register low byte: pass, shift, 32 gives bit 0, beyond gives 0.
// - Program counter in any register-shift form is unpredictable; software avoids it.
// - Right logical immediate 1..32; field zero means 32, carry bit 31.
// - Right logical by register: pass, shift, 32 gives bit 31, beyond gives 0.
// - Right arithmetic immediate 1..32 fills with sign; field zero means 32.
// - Arithmetic field zero gives all sign bits, carry the sign bit.
// - Instruction bit 25 selects immediate against register-based forms.
// - Operand fields come from instruction bits 11 down to 0.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
module bso_operand_gen
	import bso_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] shifter_operand,
	output logic shifter_carry,
	output logic [31:0] first_operand,
	output logic unpredictable
);

	// The offsets reach 0x20, so the bus needs at least six address bits.
	if (ADDR_W < 6) begin : g_addr_check
		$error("bso_operand_gen: ADDR_W must be at least 6");
	end

	// Software-visible configuration.
	logic [31:0] instr;
	logic [31:0] src_val;
	logic [31:0] amt_val;
	logic [31:0] first_val;
	logic [31:0] pc_addr;
	logic [3:0] ctrl;

	// Write channel bookkeeping.
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic [7:0] wr_off;

	// Read channel bookkeeping.
	logic [7:0] rd_off;
	logic [31:0] next_rdata;
	logic next_rd_ok;

	// Effective register values after program counter substitution.
	logic [31:0] pc_read;
	logic [31:0] src_eff;
	logic [31:0] amt_eff;
	logic [31:0] first_eff;
	logic core_carry;
	logic [31:0] core_operand;
	logic by_reg_form;
	logic pc_in_reg_form;

	// Byte lane merge for partial writes.
	function automatic logic [31:0] bso_merge(
		input logic [31:0] old_word,
		input logic [31:0] new_word,
		input logic [3:0] strb
	);
		logic [31:0] res;
		res = old_word;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_word[b*8 +: 8];
			end
		end
		return res;
	endfunction : bso_merge

	// A selected program counter reads ahead of the current instruction.
	assign pc_read = pc_addr + PC_AHEAD;
	assign src_eff = ctrl[CTRL_SRC_PC] ? pc_read : src_val;
	assign amt_eff = ctrl[CTRL_AMT_PC] ? pc_read : amt_val;
	assign first_eff = ctrl[CTRL_FIRST_PC] ? pc_read : first_val;
	assign by_reg_form = !instr[IMM_SEL_BIT] && instr[BY_REG_BIT];
	assign pc_in_reg_form = by_reg_form && (ctrl[CTRL_SRC_PC] || ctrl[CTRL_AMT_PC]
		|| ctrl[CTRL_FIRST_PC]);

	// Only the operand fields and the form select reach the shifter.
	bso_shift_core u_core (
		.instr({6'h00, instr[IMM_SEL_BIT], 13'h0000, instr[11:0]}),
		.source_value_reg(src_eff),
		.shift_amount_reg(amt_eff),
		.carry_flag(ctrl[CTRL_CARRY]),
		.operand(core_operand),
		.carry(core_carry)
	);

	// Results are captured every enabled cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn && ce) begin // Reset, too, waits for the clock enable.
			shifter_operand <= RESET_WORD;
			shifter_carry <= 1'b0;
			first_operand <= RESET_WORD;
			unpredictable <= 1'b0;
		end else if (ce) begin
			shifter_operand <= core_operand;
			shifter_carry <= core_carry;
			first_operand <= first_eff;
			unpredictable <= pc_in_reg_form;
		end
	end

	// Address and data are accepted in either order and held until written.
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_off = 8'(aw_addr);

	always_ff @(posedge aclk) begin
		if (!aresetn && ce) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn && ce) begin
			w_held <= 1'b0;
			w_data <= RESET_WORD;
			w_strb <= 4'h0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	// Ready is offered only while nothing of that channel is held.
	always_ff @(posedge aclk) begin
		if (!aresetn && ce) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (ce) begin
			s_axi_awready <= !(aw_held || (s_axi_awvalid && s_axi_awready)) && !do_write;
			s_axi_wready <= !(w_held || (s_axi_wvalid && s_axi_wready)) && !do_write;
		end
	end

	// Register writes; read-only offsets are answered with an error.
	always_ff @(posedge aclk) begin
		if (!aresetn && ce) begin
			instr <= RESET_WORD;
			src_val <= RESET_WORD;
			amt_val <= RESET_WORD;
			first_val <= RESET_WORD;
			pc_addr <= RESET_WORD;
			ctrl <= RESET_CTRL;
		end else if (ce && do_write) begin
			case (wr_off)
				ADDR_INSTR: instr <= bso_merge(instr, w_data, w_strb);
				ADDR_SRC: src_val <= bso_merge(src_val, w_data, w_strb);
				ADDR_AMT: amt_val <= bso_merge(amt_val, w_data, w_strb);
				ADDR_FIRST: first_val <= bso_merge(first_val, w_data, w_strb);
				ADDR_PC: pc_addr <= bso_merge(pc_addr, w_data, w_strb);
				ADDR_CTRL: begin
					if (w_strb[0]) begin
						ctrl <= w_data[3:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Write response.
	always_ff @(posedge aclk) begin
		if (!aresetn && ce) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (ce) begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				case (wr_off)
					ADDR_INSTR, ADDR_SRC, ADDR_AMT, ADDR_FIRST, ADDR_PC, ADDR_CTRL: begin
						s_axi_bresp <= RESP_OKAY;
					end
					default: s_axi_bresp <= RESP_SLVERR;
				endcase
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read decode.
	assign rd_off = 8'(s_axi_araddr);

	always_comb begin
		next_rdata = RESET_WORD;
		next_rd_ok = 1'b1;
		case (rd_off)
			ADDR_INSTR: next_rdata = instr;
			ADDR_SRC: next_rdata = src_val;
			ADDR_AMT: next_rdata = amt_val;
			ADDR_CTRL: next_rdata = {28'h0000000, ctrl};
			ADDR_PC: next_rdata = pc_addr;
			ADDR_RESULT: next_rdata = shifter_operand;
			ADDR_STATUS: next_rdata = {30'h00000000, unpredictable, shifter_carry};
			ADDR_FIRST: next_rdata = first_val;
			ADDR_FIRST_OUT: next_rdata = first_operand;
			default: next_rd_ok = 1'b0;
		endcase
	end

	// Read channel: one read at a time, data one cycle after the address.
	always_ff @(posedge aclk) begin
		if (!aresetn && ce) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= RESET_WORD;
			s_axi_rresp <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid) begin
				if (s_axi_rready) begin
					s_axi_rvalid <= 1'b0;
				end
			end else begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Checks on the captured results.
	a_imm_carry_keep: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && instr[IMM_SEL_BIT] && instr[ROT_HI:ROT_LO] == 4'h0
		|=> shifter_carry == $past(ctrl[CTRL_CARRY])) else $error("immediate carry not flag");
	a_imm_carry_top: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && instr[IMM_SEL_BIT] && instr[ROT_HI:ROT_LO] != 4'h0
		|=> shifter_carry == shifter_operand[31]) else $error("immediate carry not bit 31");
	a_imm_no_rotate: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && instr[IMM_SEL_BIT] && instr[ROT_HI:ROT_LO] == 4'h0
		|=> shifter_operand == {24'h000000, $past(instr[7:0])}) else $error("bad immediate");
	a_plain_register: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !instr[IMM_SEL_BIT] && instr[11:4] == 8'h00
		|=> shifter_operand == $past(src_eff) && shifter_carry == $past(ctrl[CTRL_CARRY]))
		else $error("plain register altered");
	a_left_imm_value: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !instr[IMM_SEL_BIT] && instr[6:4] == 3'h0 && instr[11:7] != 5'h00
		|=> shifter_operand == ($past(src_eff) << $past(instr[11:7]))
		&& shifter_operand[0] == 1'b0) else $error("left shift immediate wrong");
	a_left_reg_far: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !instr[IMM_SEL_BIT] && instr[6:4] == 3'h1 && amt_eff[7:0] > FULL_SHIFT
		|=> shifter_operand == 32'h0000_0000 && !shifter_carry) else $error("left far wrong");
	a_right_imm_full: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !instr[IMM_SEL_BIT] && instr[6:4] == 3'h2 && instr[11:7] == 5'h00
		|=> shifter_operand == 32'h0000_0000 && shifter_carry == $past(src_eff[31]))
		else $error("right shift by 32 wrong");
	a_right_reg_full: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !instr[IMM_SEL_BIT] && instr[6:4] == 3'h3 && amt_eff[7:0] == FULL_SHIFT
		|=> shifter_operand == 32'h0000_0000 && shifter_carry == $past(src_eff[31]))
		else $error("right register 32 wrong");
	a_arith_sign_fill: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !instr[IMM_SEL_BIT] && instr[6:4] == 3'h4 && instr[11:7] == 5'h00
		|=> shifter_operand == {32{$past(src_eff[31])}} && shifter_carry == $past(src_eff[31]))
		else $error("arithmetic fill wrong");
	a_arith_top_bit: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !instr[IMM_SEL_BIT] && instr[6:4] == 3'h4 && instr[11:7] != 5'h00
		|=> shifter_operand[31] == $past(src_eff[31])) else $error("arithmetic sign lost");
	a_pc_ahead: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && ctrl[CTRL_FIRST_PC] |=> first_operand == $past(pc_addr) + PC_AHEAD)
		else $error("program counter not ahead");
	a_pc_flagged: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && by_reg_form && ctrl[CTRL_SRC_PC] |=> unpredictable) else $error("pc not flagged");
	a_freeze_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!ce |=> $stable(shifter_operand) && $stable(shifter_carry)) else $error("moved while frozen");

endmodule : bso_operand_gen

// file: bso_axi_master.sv
module bso_axi_master (
	input wire logic aclk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	output logic rready
);
	timeunit 1ns;
	timeprecision 1ps;

	// The bus lies idle until software issues a transfer.
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// One write: address and data offered together, each released when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_left;
		logic w_left;
		aw_left = 1'b1;
		w_left = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (aw_left && awready === 1'b1) begin
				aw_left = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_left && wready === 1'b1) begin
				w_left = 1'b0;
				wvalid <= 1'b0;
			end
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask : wr

	// One read: the address stands until taken, rready until the answer.
	task automatic rd(input logic [7:0] a);
		logic ar_left;
		ar_left = 1'b1;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (ar_left && arready === 1'b1) begin
				ar_left = 1'b0;
				arvalid <= 1'b0;
			end
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask : rd
endmodule : bso_axi_master

// file: tb.sv
module tb
	import bso_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, op, fop;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	logic carry, unpred;
	logic [32:0] last_e;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [33:0] rq[$];
	logic [1:0] bq[$];

	// Clock of 4 ns.
	always #2 aclk = ~aclk;

	bso_operand_gen dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .shifter_operand(op), .shifter_carry(carry),
		.first_operand(fop), .unpredictable(unpred));

	bso_axi_master m_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rvalid(rvalid), .rready(rready));

	task automatic give_verdict();
		if (errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Each bus answer is matched against the oldest expectation noted.
	always @(posedge aclk) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			chk({rresp, rdata}, (rq.size() > 0) ? rq.pop_front() : 34'h3_FFFF_FFFF);
		end
		if (bvalid === 1'b1 && bready === 1'b1) begin
			chk({32'h0, bresp}, (bq.size() > 0) ? {32'h0, bq.pop_front()} : 34'h3_FFFF_FFFF);
		end
	end

	// A hung run is cut short and counted as a mismatch.
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			give_verdict();
		end
	end

	task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
		input logic [1:0] r = RESP_OKAY);
		bq.push_back(r);
		m_u.wr(a, d, s);
	endtask : wreg

	task automatic rreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		rq.push_back({r, d});
		m_u.rd(a);
	endtask : rreg

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C1_1DB7 : 32'h0);
	endfunction : lfsr

	// Expected {carry, operand} for the covered forms.
	function automatic logic [32:0] ref_op(input logic [31:0] ins, src, amt, input logic c);
		logic [31:0] imm;
		logic [31:0] a;
		int s;
		int n;
		imm = {24'h0, ins[7:0]};
		s = int'(ins[11:7]);
		n = int'(amt[7:0]);
		a = 32'($signed(src) >>> s);
		if (ins[25]) begin
			imm = (imm >> (2 * ins[11:8])) | (imm << (32 - 2 * ins[11:8]));
			return {(ins[11:8] == 4'h0) ? c : imm[31], imm};
		end
		if (!ins[4]) begin
			case (ins[6:5])
				2'h0: return (s == 0) ? {c, src} : {src[32 - s], src << s};
				2'h1: return (s == 0) ? {src[31], 32'h0} : {src[s - 1], src >> s};
				default: return (s == 0) ? {src[31], {32{src[31]}}} : {src[s - 1], a};
			endcase
		end
		if (n == 0) return {c, src};
		if (ins[5]) return (n < 32) ? {src[n - 1], src >> n} : {(n == 32) & src[31], 32'h0};
		return (n < 32) ? {src[32 - n], src << n} : {(n == 32) & src[0], 32'h0};
	endfunction : ref_op

	// Loads one operand setup, then checks the ports and the result registers.
	task automatic run_case(input logic [31:0] ins, src, amt, input logic [3:0] ct,
		input logic [31:0] pc, fv);
		logic [31:0] fx;
		logic up;
		fx = ct[3] ? pc + PC_AHEAD : fv;
		up = !ins[25] && ins[4] && (ct[3:1] != 3'h0);
		last_e = ref_op(ins, ct[1] ? pc + PC_AHEAD : src, ct[2] ? pc + PC_AHEAD : amt, ct[0]);
		wreg(ADDR_INSTR, ins);
		wreg(ADDR_SRC, src);
		wreg(ADDR_AMT, amt);
		wreg(ADDR_CTRL, {28'h0, ct});
		wreg(ADDR_PC, pc);
		wreg(ADDR_FIRST, fv);
		repeat (2) @(posedge aclk);
		#1;
		chk({2'h0, op}, {2'h0, last_e[31:0]});
		chk({33'h0, carry}, {33'h0, last_e[32]});
		chk({2'h0, fop}, {2'h0, fx});
		chk({33'h0, unpred}, {33'h0, up});
		rreg(ADDR_RESULT, last_e[31:0]);
		rreg(ADDR_STATUS, {30'h0, up, last_e[32]});
		rreg(ADDR_FIRST_OUT, fx);
	endtask : run_case

	// Main sequence: reset values, bus refusals, boundary cases, then random forms.
	initial begin
		logic [31:0] x, ins, amt;
		logic [31:0] nv [7];
		nv = '{0, 1, 31, 32, 33, 255, 32'h104};
		x = 32'h78F5_59A5;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rreg(ADDR_INSTR, RESET_WORD);
		rreg(ADDR_CTRL, {28'h0, RESET_CTRL});
		wreg(ADDR_SRC, 32'h1122_3344);
		wreg(ADDR_SRC, 32'hAABB_CCDD, 4'h5);
		rreg(ADDR_SRC, 32'h11BB_33DD);
		wreg(ADDR_CTRL, 32'hFFFF_FFFF);
		rreg(ADDR_CTRL, 32'h0000_000F);
		wreg(ADDR_RESULT, 32'h1, 4'hF, RESP_SLVERR);
		wreg(8'h28, 32'h1, 4'hF, RESP_SLVERR);
		rreg(8'h24, 32'h0, RESP_SLVERR);
		for (int r = 0; r < 16; r++) begin
			run_case(32'(32'h0200_0081 | (r << 8)), 32'hDEAD_BEEF, 0, 4'(r) ^ 4'h1,
				32'(32'h1000 + r * 4), 32'h5A5A_0000);
		end
		for (int t = 0; t < 3; t++) begin
			for (int k = 0; k < 6; k++) begin
				ins = 32'((((k % 3 == 0) ? 0 : (k % 3 == 1) ? 1 : 31) << 7) | (t << 5));
				run_case(ins, (k < 3) ? 32'h8000_0001 : 32'h7FFF_FFFE, 0, 4'(k) & 4'h3,
					32'hF000_0004, 0);
			end
		end
		for (int t = 0; t < 2; t++) begin
			for (int k = 0; k < 14; k++) begin
				run_case(32'(32'h10 | (t << 5)), (k < 7) ? 32'h8000_0001 : 32'h7FFF_FFFE,
					nv[k % 7], 4'(k % 2), 0, 0);
			end
		end
		run_case(32'h0000_0011, 32'h3, 32'h2, 4'h8, 32'h200, 32'h7);
		// Hold the clock enable low, first alone and then across a reset.
		ce <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		#1;
		chk({2'h0, op}, {2'h0, last_e[31:0]});
		chk({33'h0, carry}, {33'h0, last_e[32]});
		@(posedge aclk);
		ce <= 1'b1;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rreg(ADDR_INSTR, RESET_WORD);
		rreg(ADDR_RESULT, RESET_WORD);
		for (int i = 0; i < 40; i++) begin
			x = lfsr(x);
			ins = x;
			x = lfsr(x);
			amt = x[0] ? {x[31:8], 2'h0, x[13:8]} : x;
			if (!ins[25] && ins[6]) ins[5:4] = 2'h0;
			x = lfsr(x);
			run_case(ins, lfsr(x), amt, x[3:0], {x[31:2], 2'h0}, lfsr(amt));
		end
		repeat (5) @(posedge aclk);
		chk({2'h0, 32'(rq.size() + bq.size())}, 34'h0);
		give_verdict();
	end
endmodule : tb
